// ---- cct_timer16.sv ----
// sixteen bit capture compare timer with APB register slave
//
// Added by the designer: the register offsets and the APB interface to the registers.
`default_nettype none
module cct_timer16
	import cct_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu side
	input wire logic haltMode,
	input wire logic cpuIntMask,
	output logic irqReq,
	// pins
	input wire logic extTickPin,
	input wire logic [1:0] capturePin,
	output logic [1:0] comparePin,
	output logic [1:0] comparePinOe
);

	////////////////////////////////////////////////////////////////////////////////
	localparam cct_state_s ST_RESET = '{
		count: CNT_RESET, presc: PRESC_RESET, ctrl1: CTRL_RESET, ctrl2: CTRL_RESET,
		cmpVal: {CMP_RESET, CMP_RESET}, default: '0};

	cct_state_s q;
	cct_state_s n;
	logic setupPh;
	logic done;
	logic rd;
	logic wr;
	logic tick;
	logic extEdge;
	logic ovfWrap;
	logic cntLoAcc;
	logic altLoAcc;
	logic [1:0] capEv;
	logic [1:0] capLoAcc;
	logic [1:0] cmpLoAcc;
	logic [1:0] cmpMatch;
	logic [1:0] pinEn;
	logic [1:0] olvl;

	function automatic logic [7:0] chanAddr(input logic [7:0] base, input logic ch);
		chanAddr = ch ? 8'(base + ADDR_CH_STRIDE) : base;
	endfunction

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a[1:0] == 2'h0) && (a <= 8'h38);
	endfunction

	function automatic logic [7:0] readByte(input cct_state_s s, input logic [7:0] a);
		readByte = 8'h00;
		unique case (a)
			ADDR_CTRL1: readByte = s.ctrl1;
			ADDR_CTRL2: readByte = s.ctrl2;
			ADDR_STATUS: readByte = {3'h0, s.cmpFlag, s.capFlag, s.ovfFlag};
			ADDR_CNT_HI, ADDR_ALT_HI: readByte = s.count[15:8];
			// buffered byte after a high read, live byte otherwise
			ADDR_CNT_LO, ADDR_ALT_LO: readByte = s.cntLatched ? s.cntLoHold : s.count[7:0];
			ADDR_CAP1_HI: readByte = s.capVal[0][15:8];
			ADDR_CAP1_LO: readByte = s.capVal[0][7:0];
			chanAddr(ADDR_CAP1_HI, 1'b1): readByte = s.capVal[1][15:8];
			chanAddr(ADDR_CAP1_LO, 1'b1): readByte = s.capVal[1][7:0];
			ADDR_CMP1_HI: readByte = s.cmpVal[0][15:8];
			ADDR_CMP1_LO: readByte = s.cmpVal[0][7:0];
			chanAddr(ADDR_CMP1_HI, 1'b1): readByte = s.cmpVal[1][15:8];
			chanAddr(ADDR_CMP1_LO, 1'b1): readByte = s.cmpVal[1][7:0];
			default: readByte = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n = q;
		// bus phases; effects only at the completing edge
		setupPh = psel && !penable;
		done = psel && penable && q.pready;
		rd = done && !pwrite;
		wr = done && pwrite && !q.pslverr;
		n.pready = setupPh;
		n.pslverr = setupPh && !isMapped(paddr);
		n.prdata = setupPh ? {24'h000000, readByte(q, paddr)} : q.prdata;

		// three-stage pin filters; stage one only feeds stage two
		n.extSync = {q.extSync[1:0], extTickPin};
		n.extLvl = (q.extSync[1] == q.extSync[2]) ? q.extSync[2] : q.extLvl;
		extEdge = (n.extLvl != q.extLvl) && (n.extLvl == q.ctrl2[C2_EXT_EDGE]);
		for (int i = 0; i < 2; i++)
		begin
			n.capSync[i] = {q.capSync[i][1:0], capturePin[i]};
			n.capLvl[i] = (q.capSync[i][1] == q.capSync[i][2]) ? q.capSync[i][2] : q.capLvl[i];
		end

		// prescaler gives a one-cycle enable; clk_sys edge is the cpu counting edge
		n.presc = 3'(q.presc + 3'h1);
		unique case (cct_tsel_e'(q.ctrl2[C2_TSEL +: 2]))
			TS_DIV2: tick = q.presc[0];
			TS_DIV4: tick = &q.presc[1:0];
			TS_DIV8: tick = &q.presc;
			TS_EXT: tick = extEdge;
		endcase
		tick = tick && !haltMode;

		// control writes
		if (wr && paddr == ADDR_CTRL1)
			n.ctrl1 = pwdata[7:0];
		if (wr && paddr == ADDR_CTRL2)
			n.ctrl2 = pwdata[7:0];

		// status read arms each flag that is set
		if (rd && paddr == ADDR_STATUS)
		begin
			n.ovfArm = q.ovfFlag;
			n.capArm = q.capFlag;
			n.cmpArm = q.cmpFlag;
		end

		// counter
		cntLoAcc = done && paddr == ADDR_CNT_LO;
		altLoAcc = done && paddr == ADDR_ALT_LO;
		ovfWrap = tick && q.count == CNT_MAX;
		if (tick)
			n.count = 16'(q.count + 16'h0001);
		if (wr && (paddr == ADDR_CNT_LO || paddr == ADDR_ALT_LO))
			n.count = CNT_RESET;
		if (rd && (paddr == ADDR_CNT_HI || paddr == ADDR_ALT_HI) && !q.cntLatched)
		begin
			n.cntLatched = 1'b1;
			n.cntLoHold = q.count[7:0];
		end
		if (rd && (paddr == ADDR_CNT_LO || paddr == ADDR_ALT_LO))
			n.cntLatched = 1'b0;
		// only the main low byte finishes the clear, never the alternate one
		if (cntLoAcc && q.ovfArm)
		begin
			n.ovfFlag = 1'b0;
			n.ovfArm = 1'b0;
		end
		if (ovfWrap)
			n.ovfFlag = 1'b1;

		// capture channels
		pinEn = {q.ctrl2[C2_PIN_EN2], q.ctrl2[C2_PIN_EN1]};
		olvl = {q.ctrl1[C1_OLVL2], q.ctrl1[C1_OLVL1]};
		for (int i = 0; i < 2; i++)
		begin
			capLoAcc[i] = done && paddr == chanAddr(ADDR_CAP1_LO, 1'(i));
			cmpLoAcc[i] = done && paddr == chanAddr(ADDR_CMP1_LO, 1'(i));
			if (rd && paddr == chanAddr(ADDR_CAP1_HI, 1'(i)))
				n.capBlock[i] = 1'b1;
			if (rd && capLoAcc[i])
				n.capBlock[i] = 1'b0;
			if (capLoAcc[i] && q.capArm[i])
			begin
				n.capFlag[i] = 1'b0;
				n.capArm[i] = 1'b0;
			end
			capEv[i] = (n.capLvl[i] != q.capLvl[i])
				&& (n.capLvl[i] == (i == 0 ? q.ctrl1[C1_CAP_EDGE] : q.ctrl2[C2_CAP_EDGE]))
				&& !q.capBlock[i]
				&& !(i == 0 && (q.ctrl2[C2_SPM] || q.ctrl2[C2_PWM]));
			if (capEv[i])
			begin
				n.capVal[i] = q.count;
				n.capFlag[i] = 1'b1;
			end

			// compare channels
			if (wr && paddr == chanAddr(ADDR_CMP1_HI, 1'(i)))
			begin
				n.cmpVal[i][15:8] = pwdata[7:0];
				n.cmpInhibit[i] = 1'b1;
			end
			if (wr && cmpLoAcc[i])
			begin
				n.cmpVal[i][7:0] = pwdata[7:0];
				n.cmpInhibit[i] = 1'b0;
			end
			if (cmpLoAcc[i] && q.cmpArm[i])
			begin
				n.cmpFlag[i] = 1'b0;
				n.cmpArm[i] = 1'b0;
			end
			// checked against the new count at every tick while not inhibited
			cmpMatch[i] = tick && !n.cmpInhibit[i] && n.count == q.cmpVal[i];
			if (cmpMatch[i])
			begin
				n.cmpFlag[i] = 1'b1;
				if (pinEn[i])
					n.cmpPin[i] = olvl[i];
			end
		end

		// one request line; held off while the cpu mask is set, so it stays pending
		n.irqReq = !cpuIntMask && (
			(n.ovfFlag && q.ctrl1[C1_OVF_IE])
			|| ((|n.capFlag) && q.ctrl1[C1_CAP_IE])
			|| ((|n.cmpFlag) && q.ctrl1[C1_CMP_IE]));
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			q <= ST_RESET;
		else
			q <= n;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign irqReq = q.irqReq;
	assign comparePin = q.cmpPin;
	assign comparePinOe = {q.ctrl2[C2_PIN_EN2], q.ctrl2[C2_PIN_EN1]};

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence s_statusRead;
		rd && paddr == ADDR_STATUS && q.ovfFlag;
	endsequence

	sequence s_mainLoAccess;
		cntLoAcc && q.ovfArm && !ovfWrap;
	endsequence

	property p_loWriteReload;
		wr && paddr == ADDR_CNT_LO |=> q.count == 16'hFFFC;
	endproperty
	a_loWriteReload: assert property (p_loWriteReload)
		else $error("counter not reloaded by low byte write");

	property p_resetCount;
		$rose(reset_n) |-> q.count == 16'hFFFC && q.cmpVal[0] == 16'h8000 && !q.cmpPin[0];
	endproperty
	a_resetCount: assert property (p_resetCount)
		else $error("wrong value after reset");

	property p_holdLow;
		q.cntLatched && !(rd && (paddr == ADDR_CNT_LO || paddr == ADDR_ALT_LO))
			|=> q.cntLatched && $stable(q.cntLoHold);
	endproperty
	a_holdLow: assert property (p_holdLow)
		else $error("buffered low byte changed");

	property p_ovfSet;
		ovfWrap && !wr |=> q.ovfFlag && q.count == 16'h0000;
	endproperty
	a_ovfSet: assert property (p_ovfSet)
		else $error("overflow flag not set on wrap");

	property p_irqMask;
		cpuIntMask |=> !q.irqReq;
	endproperty
	a_irqMask: assert property (p_irqMask)
		else $error("interrupt raised while masked");

	property p_ovfClear;
		s_statusRead ##[1:20] s_mainLoAccess |=> !q.ovfFlag;
	endproperty
	a_ovfClear: assert property (p_ovfClear)
		else $error("overflow flag not cleared");

	property p_altKeeps;
		q.ovfFlag && altLoAcc |=> q.ovfFlag;
	endproperty
	a_altKeeps: assert property (p_altKeeps)
		else $error("alternate access cleared overflow");

	property p_haltFreeze;
		haltMode && !wr |=> $stable(q.count);
	endproperty
	a_haltFreeze: assert property (p_haltFreeze)
		else $error("counter moved in halt");

	property p_capture;
		capEv[1] |=> q.capVal[1] == $past(q.count) && q.capFlag[1];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value or flag wrong");

	property p_capBlock;
		q.capBlock[0] |=> $stable(q.capVal[0]);
	endproperty
	a_capBlock: assert property (p_capBlock)
		else $error("capture taken while blocked");

	property p_cmpPin;
		cmpMatch[0] && q.ctrl2[C2_PIN_EN1]
			|=> q.cmpPin[0] == $past(q.ctrl1[C1_OLVL1]) && q.cmpFlag[0];
	endproperty
	a_cmpPin: assert property (p_cmpPin)
		else $error("compare pin or flag wrong after match");

	property p_cmpInhibit;
		q.cmpInhibit[0] && !q.cmpFlag[0] && !(wr && cmpLoAcc[0]) |=> !q.cmpFlag[0];
	endproperty
	a_cmpInhibit: assert property (p_cmpInhibit)
		else $error("compare matched while inhibited");

	property p_altReload;
		wr && paddr == ADDR_ALT_LO |=> q.count == 16'hFFFC;
	endproperty
	a_altReload: assert property (p_altReload)
		else $error("counter not reloaded by alternate low byte write");

	property p_tickCount;
		tick && !wr |=> q.count == 16'($past(q.count) + 16'h0001);
	endproperty
	a_tickCount: assert property (p_tickCount)
		else $error("counter did not advance by one on a tick");

	property p_latchOnHigh;
		rd && (paddr == ADDR_CNT_HI || paddr == ADDR_ALT_HI) && !q.cntLatched
			|=> q.cntLatched && q.cntLoHold == $past(q.count[7:0]);
	endproperty
	a_latchOnHigh: assert property (p_latchOnHigh)
		else $error("low byte not buffered by high byte read");

	property p_liveLow;
		setupPh && (paddr == ADDR_CNT_LO || paddr == ADDR_ALT_LO) && !q.cntLatched
			|=> q.prdata[7:0] == $past(q.count[7:0]);
	endproperty
	a_liveLow: assert property (p_liveLow)
		else $error("unbuffered low byte read not live");

	property p_ovfArm;
		s_statusRead |=> q.ovfArm;
	endproperty
	a_ovfArm: assert property (p_ovfArm)
		else $error("status read did not arm the overflow clear");

	// a pending overflow flag must raise the request as soon as enable and mask allow
	property p_ovfIrq;
		q.ovfFlag && q.ctrl1[C1_OVF_IE] && !cpuIntMask && !(cntLoAcc && q.ovfArm)
			|=> q.irqReq;
	endproperty
	a_ovfIrq: assert property (p_ovfIrq)
		else $error("pending overflow request not raised");

	property p_extTick;
		q.ctrl2[C2_TSEL +: 2] == 2'b11 && !extEdge && !wr |=> $stable(q.count);
	endproperty
	a_extTick: assert property (p_extTick)
		else $error("counter moved without an external edge");

	property p_ch1Blocked;
		q.ctrl2[C2_SPM] || q.ctrl2[C2_PWM] |-> !capEv[0];
	endproperty
	a_ch1Blocked: assert property (p_ch1Blocked)
		else $error("channel one captured in pulse or pwm mode");

	property p_cmpHold;
		!(wr && (paddr == ADDR_CMP1_HI || paddr == ADDR_CMP1_LO))
			|=> $stable(q.cmpVal[0]);
	endproperty
	a_cmpHold: assert property (p_cmpHold)
		else $error("compare register changed without a write");

	property p_readyPulse;
		q.pready |=> !q.pready && !q.pslverr;
	endproperty
	a_readyPulse: assert property (p_readyPulse)
		else $error("bus answer held longer than one cycle");

endmodule // cct_timer16
`default_nettype wire

// ---- cct_pkg.sv ----
// constants, types and register map of the capture compare timer
`default_nettype none
package cct_pkg;
	localparam logic [15:0] CNT_RESET = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CMP_RESET = 16'h8000;
	localparam logic [2:0] PRESC_RESET = 3'h0;
	// register byte addresses, one byte per 32-bit word
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
	localparam logic [7:0] ADDR_CNT_LO = 8'h10;
	localparam logic [7:0] ADDR_ALT_HI = 8'h14;
	localparam logic [7:0] ADDR_ALT_LO = 8'h18;
	localparam logic [7:0] ADDR_CAP1_HI = 8'h1C;
	localparam logic [7:0] ADDR_CAP1_LO = 8'h20;
	localparam logic [7:0] ADDR_CMP1_HI = 8'h2C;
	localparam logic [7:0] ADDR_CMP1_LO = 8'h30;
	localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
	// control_one fields
	localparam int C1_OVF_IE = 0;
	localparam int C1_CAP_IE = 1;
	localparam int C1_CMP_IE = 2;
	localparam int C1_CAP_EDGE = 3;
	localparam int C1_OLVL1 = 4;
	localparam int C1_OLVL2 = 5;
	// control_two fields
	localparam int C2_TSEL = 0;
	localparam int C2_EXT_EDGE = 2;
	localparam int C2_CAP_EDGE = 3;
	localparam int C2_PIN_EN1 = 4;
	localparam int C2_PIN_EN2 = 5;
	localparam int C2_SPM = 6;
	localparam int C2_PWM = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// timer_flags fields
	localparam int ST_OVF = 0;
	localparam int ST_CAP = 1;
	localparam int ST_CMP = 3;

	typedef enum logic [1:0] {TS_DIV4, TS_DIV2, TS_DIV8, TS_EXT} cct_tsel_e;

	typedef struct packed {
		logic [15:0] count;
		logic [2:0] presc;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic ovfFlag;
		logic [1:0] capFlag;
		logic [1:0] cmpFlag;
		logic ovfArm;
		logic [1:0] capArm;
		logic [1:0] cmpArm;
		logic cntLatched;
		logic [7:0] cntLoHold;
		logic [1:0][15:0] capVal;
		logic [1:0] capBlock;
		logic [1:0][15:0] cmpVal;
		logic [1:0] cmpInhibit;
		logic [1:0] cmpPin;
		logic [2:0] extSync;
		logic extLvl;
		logic [1:0][2:0] capSync;
		logic [1:0] capLvl;
		logic irqReq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cct_state_s;
endpackage : cct_pkg
`default_nettype wire

// ---- cct_pin_model.sv ----
// pin side model: external tick source and capture pins
`default_nettype none
module cct_pin_model
(
	// clock
	input wire logic clk_sys,
	// commands from the bench
	input wire logic tickRun,
	input wire logic [1:0] capSet,
	// pins
	output logic extTickPin,
	output logic [1:0] capturePin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] gap;
	initial
	begin
		extTickPin = 1'b0;
		capturePin = 2'b00;
		gap = 3'h0;
	end
	always @(posedge clk_sys)
	begin
		capturePin <= capSet;
		if (tickRun)
		begin
			gap <= (gap == 3'h4) ? 3'h0 : gap + 3'h1;
			// ten cycles per period keeps edges well apart
			if (gap == 3'h4)
				extTickPin <= ~extTickPin;
		end
	end
endmodule // cct_pin_model
`default_nettype wire

// ---- tb_cct_timer16.sv ----
// self-checking bench of the capture compare timer
`default_nettype none
module tb_cct_timer16
	import cct_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic haltMode = 1'b1;
	logic cpuIntMask = 1'b1;
	logic tickRun = 1'b0;
	logic [1:0] capSet = 2'b00;
	logic [31:0] prdata;
	logic pready, pslverr, irqReq, extTickPin;
	logic [1:0] capturePin, comparePin, comparePinOe;
	logic [7:0] rd;
	logic err;
	int n_mismatch = 0;
	int checks = 0;
	////////////////////////////////////////////////////////////////
	cct_timer16 DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .haltMode(haltMode), .cpuIntMask(cpuIntMask), .irqReq(irqReq),
		.extTickPin(extTickPin), .capturePin(capturePin), .comparePin(comparePin),
		.comparePinOe(comparePinOe));
	cct_pin_model PINS (.clk_sys(clk_sys), .tickRun(tickRun), .capSet(capSet),
		.extTickPin(extTickPin), .capturePin(capturePin));
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		// no fixed latency assumed; answer looked at mid-cycle, while it stands
		do
		begin
			@(negedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			$display("ERROR at %0t got %h expected %h", $time, pready, 1'b1);
			n_mismatch++;
		end
		rd = prdata[7:0];
		err = pslverr;
		// completing edge: the write lands here, only then is the request released
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		if (got !== exp)
		begin
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
		checks++;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// counter is held by halt so every value is exact
	task automatic t_reset();
		rchk(ADDR_CMP1_HI, CMP_RESET[15:8]);
		rchk(ADDR_CMP1_LO, CMP_RESET[7:0]);
		rchk(ADDR_CTRL1, CTRL_RESET);
		rchk(ADDR_STATUS, 8'h00);
		rchk(ADDR_CNT_HI, CNT_RESET[15:8]);
		rchk(ADDR_CNT_LO, CNT_RESET[7:0]);
		rchk(ADDR_ALT_HI, CNT_RESET[15:8]);
		rchk(ADDR_ALT_LO, CNT_RESET[7:0]);
	endtask
	task automatic t_reload(input logic [7:0] a);
		haltMode <= 1'b0;
		cyc(6);
		haltMode <= 1'b1;
		apb(1'b1, a, 8'h55);
		rchk(ADDR_CNT_HI, CNT_RESET[15:8]);
		rchk(ADDR_CNT_LO, CNT_RESET[7:0]);
	endtask
	task automatic t_latch();
		rchk(ADDR_CNT_HI, 8'hFF);
		haltMode <= 1'b0;
		cyc(20);
		haltMode <= 1'b1;
		rchk(ADDR_CNT_HI, 8'h00);
		rchk(ADDR_CNT_LO, 8'hFC);
		// ten ticks from FFFCh give 0006h
		rchk(ADDR_CNT_LO, 8'h06);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_OVF]}, 8'h01);
	endtask
	task automatic t_ovf();
		apb(1'b1, ADDR_CTRL1, 8'h01);
		cyc(3);
		chk({7'h00, irqReq}, 8'h00);
		cpuIntMask <= 1'b0;
		cyc(3);
		chk({7'h00, irqReq}, 8'h01);
		apb(1'b0, ADDR_ALT_LO, 8'h00);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_OVF]}, 8'h01);
		apb(1'b0, ADDR_CNT_LO, 8'h00);
		rchk(ADDR_STATUS, 8'h00);
		chk({7'h00, irqReq}, 8'h00);
		apb(1'b1, ADDR_CTRL1, 8'h00);
	endtask
	task automatic t_capture();
		apb(1'b1, ADDR_CNT_LO, 8'h00);
		apb(1'b1, ADDR_CTRL1, 8'h08);
		capSet <= 2'b01;
		cyc(8);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_CAP]}, 8'h01);
		rchk(ADDR_CAP1_HI, 8'hFF);
		haltMode <= 1'b0;
		cyc(10);
		haltMode <= 1'b1;
		capSet <= 2'b00;
		cyc(6);
		capSet <= 2'b01;
		cyc(8);
		rchk(ADDR_CAP1_LO, 8'hFC);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_CAP]}, 8'h00);
	endtask
	task automatic t_compare();
		apb(1'b1, ADDR_CNT_LO, 8'h00);
		apb(1'b1, ADDR_CMP1_HI, 8'hFF);
		apb(1'b1, ADDR_CMP1_LO, 8'hFE);
		apb(1'b1, ADDR_CTRL1, 8'h10);
		apb(1'b1, ADDR_CTRL2, 8'h11);
		cyc(3);
		chk({6'h00, comparePinOe}, 8'h01);
		chk({6'h00, comparePin}, 8'h00);
		haltMode <= 1'b0;
		cyc(10);
		haltMode <= 1'b1;
		cyc(2);
		chk({6'h00, comparePin}, 8'h01);
		rchk(ADDR_CMP1_HI, 8'hFF);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_CMP]}, 8'h01);
		// high write inhibits, low read clears the flag but keeps the inhibit
		apb(1'b1, ADDR_CMP1_HI, 8'hFF);
		rchk(ADDR_CMP1_LO, 8'hFE);
		apb(1'b1, ADDR_CTRL1, 8'h00);
		apb(1'b1, ADDR_CNT_LO, 8'h00);
		haltMode <= 1'b0;
		cyc(10);
		haltMode <= 1'b1;
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({7'h00, rd[ST_CMP]}, 8'h00);
		chk({6'h00, comparePin}, 8'h01);
		apb(1'b1, ADDR_CMP1_LO, 8'hFE);
	endtask
	task automatic t_capture2();
		apb(1'b1, ADDR_CTRL2, 8'h49);
		apb(1'b1, ADDR_CTRL1, 8'h08);
		apb(1'b1, ADDR_CNT_LO, 8'h00);
		capSet <= 2'b00;
		cyc(8);
		// both pins rise; single pulse mode leaves only channel two
		capSet <= 2'b11;
		cyc(8);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({6'h00, rd[ST_CAP +: 2]}, 8'h02);
		rchk(8'(ADDR_CAP1_HI + ADDR_CH_STRIDE), CNT_RESET[15:8]);
		rchk(8'(ADDR_CAP1_LO + ADDR_CH_STRIDE), CNT_RESET[7:0]);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk({6'h00, rd[ST_CAP +: 2]}, 8'h00);
	endtask
	task automatic t_ext();
		apb(1'b1, ADDR_CTRL2, 8'h07);
		haltMode <= 1'b0;
		apb(1'b1, ADDR_ALT_LO, 8'h00);
		cyc(20);
		rchk(ADDR_ALT_LO, 8'hFC);
		tickRun <= 1'b1;
		cyc(100);
		tickRun <= 1'b0;
		cyc(10);
		rchk(ADDR_ALT_HI, 8'h00);
		// ten rising edges from FFFCh; counting both edges would give 10h
		rchk(ADDR_ALT_LO, 8'h06);
		haltMode <= 1'b1;
	endtask
	task automatic t_unmapped();
		apb(1'b0, 8'h3C, 8'h00);
		chk({7'h00, err}, 8'h01);
		chk(rd, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#(40 * 50000);
		n_mismatch++;
		stop_test();
	end
	initial
	begin
		cyc(12);
		reset_n <= 1'b1;
		t_reset();
		apb(1'b1, ADDR_CTRL2, 8'h01);
		t_reload(ADDR_CNT_LO);
		t_reload(ADDR_ALT_LO);
		t_latch();
		t_ovf();
		t_capture();
		t_compare();
		t_capture2();
		t_ext();
		t_unmapped();
		stop_test();
	end
endmodule // tb_cct_timer16
`default_nettype wire
